// *** cev_pkg.sv ***
package cev_pkg;

  localparam logic [31:0] CEV_CTRL_OFF = 32'h0000_0000;
  localparam logic [31:0] CEV_OPT_OFF = 32'h0000_0004;

  localparam int CEV_EN_BIT = 7;
  localparam int CEV_REF_BIT = 6;
  localparam int CEV_FLAG_BIT = 5;
  localparam int CEV_IE_BIT = 4;
  localparam int CEV_LVL_BIT = 3;
  localparam int CEV_OPE_BIT = 2;
  localparam int CEV_MODE_LSB = 0;
  localparam int CEV_ROUTE_BIT = 0;
  localparam int CEV_STRB_LANE = 0;

  localparam logic [7:0] CEV_CTRL_RST = 8'h00;
  localparam logic CEV_ROUTE_RST = 1'b0;

  localparam logic [1:0] CEV_RESP_OKAY = 2'h0;
  localparam logic [1:0] CEV_RESP_SLVERR = 2'h2;

  // Ordinals match the edge mode field encodings
  typedef enum logic [1:0] {
    CEV_FALL_A,
    CEV_RISE,
    CEV_FALL_B,
    CEV_BOTH
  } cev_mode_t;

  // Layout follows the status/control register, bit 7 first
  typedef struct packed {
    logic en;
    logic ref_sel;
    logic flag;
    logic ie;
    logic lvl;
    logic ope;
    cev_mode_t mode;
  } cev_ctrl_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } cev_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cev_axi_resp_t;

  typedef struct packed {
    logic en;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } cev_wr_t;

endpackage

// *** cev_sync.sv ***
module cev_sync
  import cev_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign level = s2;
  assign rise = s2 && !s3;
  assign fall = !s2 && s3;
endmodule

// *** cev_axil.sv ***
module cev_axil
  import cev_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input cev_axi_req_t req,
  output cev_axi_resp_t resp,
  output cev_wr_t wr,
  input wire logic [31:0] rd_word
);
  logic aw_rdy, next_aw_rdy, w_rdy, next_w_rdy, ar_rdy, next_ar_rdy;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] awaddr, next_awaddr, wdata, next_wdata, rdata, next_rdata;
  logic [3:0] wstrb, next_wstrb;
  logic do_wr;

  function automatic logic mapped(input logic [31:0] a);
    mapped = (a == CEV_CTRL_OFF) || (a == CEV_OPT_OFF);
  endfunction

  // Write only once both halves are held and no response is pending
  assign do_wr = !aw_rdy && !w_rdy && !bvalid;

  always_comb
  begin
    next_aw_rdy = aw_rdy;
    next_w_rdy = w_rdy;
    next_ar_rdy = ar_rdy;
    next_bvalid = bvalid;
    next_rvalid = rvalid;
    next_bresp = bresp;
    next_rresp = rresp;
    next_awaddr = awaddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_rdata = rdata;
    if (aw_rdy && req.awvalid)
    begin
      next_aw_rdy = 1'b0;
      next_awaddr = req.awaddr;
    end
    if (w_rdy && req.wvalid)
    begin
      next_w_rdy = 1'b0;
      next_wdata = req.wdata;
      next_wstrb = req.wstrb;
    end
    if (do_wr)
    begin
      next_aw_rdy = 1'b1;
      next_w_rdy = 1'b1;
      next_bvalid = 1'b1;
      next_bresp = mapped(awaddr) ? CEV_RESP_OKAY : CEV_RESP_SLVERR;
    end
    if (bvalid && req.bready)
      next_bvalid = 1'b0;
    if (ar_rdy && req.arvalid)
    begin
      next_ar_rdy = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = mapped(req.araddr) ? CEV_RESP_OKAY : CEV_RESP_SLVERR;
    end
    if (rvalid && req.rready)
    begin
      next_rvalid = 1'b0;
      next_ar_rdy = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_rdy <= 1'b1;
      w_rdy <= 1'b1;
      ar_rdy <= 1'b1;
      bvalid <= 1'b0;
      rvalid <= 1'b0;
      bresp <= CEV_RESP_OKAY;
      rresp <= CEV_RESP_OKAY;
      awaddr <= 32'h0000_0000;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      aw_rdy <= next_aw_rdy;
      w_rdy <= next_w_rdy;
      ar_rdy <= next_ar_rdy;
      bvalid <= next_bvalid;
      rvalid <= next_rvalid;
      bresp <= next_bresp;
      rresp <= next_rresp;
      awaddr <= next_awaddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      rdata <= next_rdata;
    end
  end

  assign wr = '{en: do_wr && mapped(awaddr), addr: awaddr, data: wdata, strb: wstrb};
  assign resp = '{awready: aw_rdy, wready: w_rdy, bvalid: bvalid, bresp: bresp,
                  arready: ar_rdy, rvalid: rvalid, rdata: rdata, rresp: rresp};
endmodule

// *** cev_top.sv ***
// Function
// - Control bit 7 enables the whole comparator block.
// - Bit 6 picks positive pin (0) or internal reference (1) as plus input.
// - Selected compare event on the output sets the flag at bit 5.
// - Writing one clears the flag; writing zero leaves it.
// - With bit 4 set, interrupt request stands while the flag is set.
// - Bit 3 reads live comparator output; zero while disabled and after reset.
// - Bit 2 drives comparator output onto the output pin.
// - Mode 00/10 falling, 01 rising, 11 either edge.
// - Capture route feeds timer channel 0 and hides its pin.
// - Enabled comparator keeps running in wait and can wake the processor.
// - Light stop: keeps comparing, driving pin, flagging and waking.
// - Reset leaving stop restores block and register to reset state.
// - Deep stop powers the block down; it wakes in reset state.
// - Background debug halt leaves the comparator fully working.
// - Minus input always comes from the negative input pin.
// - Output is high when plus input exceeds minus input, else low.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
module cev_top
  import cev_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input cev_axi_req_t axi_req,
  output cev_axi_resp_t axi_resp,
  input wire logic cmp_raw,
  input wire logic timer_pin_in,
  input wire logic wait_mode,
  input wire logic stop_light,
  input wire logic stop_deep,
  output logic analog_enable,
  output logic noninv_sel_ref,
  output logic cmp_out_pin,
  output logic cmp_out_pin_oe_n,
  output logic timer_capture_ch0_in,
  output logic timer_pin_disable,
  output logic irq,
  output logic wake_req
);
  cev_wr_t wr;
  cev_ctrl_t ctrl;
  cev_ctrl_t next_ctrl;
  logic route;
  logic next_route;
  logic sync_lvl;
  logic rise;
  logic fall;
  logic evt;
  logic [31:0] rd_word;
  logic next_analog_enable;
  logic next_noninv_sel_ref;
  logic next_cmp_out_pin;
  logic next_cmp_out_pin_oe_n;
  logic next_timer_capture_ch0_in;
  logic next_timer_pin_disable;
  logic next_irq;
  logic next_wake_req;
  logic ctrl_wr;
  logic opt_wr;

  cev_axil u_axil (
    .clk(clk),
    .nrst(nrst),
    .req(axi_req),
    .resp(axi_resp),
    .wr(wr),
    .rd_word(rd_word)
  );

  // The raw output is high when plus exceeds minus; it is asynchronous
  cev_sync u_sync (
    .clk(clk),
    .nrst(nrst),
    .din(cmp_raw),
    .level(sync_lvl),
    .rise(rise),
    .fall(fall)
  );

  assign ctrl_wr = wr.en && wr.strb[CEV_STRB_LANE] && (wr.addr == CEV_CTRL_OFF);
  assign opt_wr = wr.en && wr.strb[CEV_STRB_LANE] && (wr.addr == CEV_OPT_OFF);

  // Edges come from synchronised samples, one pulse per transition
  always_comb
  begin
    case (ctrl.mode)
      CEV_RISE: evt = rise;
      CEV_BOTH: evt = rise || fall;
      CEV_FALL_A: evt = fall;
      default: evt = fall;
    endcase
    evt = evt && ctrl.en;
  end

  // No gating on wait, light stop or debug halt
  always_comb
  begin
    next_ctrl = ctrl;
    next_route = route;
    if (ctrl_wr)
    begin
      next_ctrl = cev_ctrl_t'(wr.data[7:0]);
      next_ctrl.flag = ctrl.flag && !wr.data[CEV_FLAG_BIT];
    end
    if (opt_wr)
      next_route = wr.data[CEV_ROUTE_BIT];
    // Set beats a clear landing in the same cycle
    if (evt)
      next_ctrl.flag = 1'b1;
    next_ctrl.lvl = next_ctrl.en && sync_lvl;
    // Powered down: contents lost, so wake-up finds reset values
    if (stop_deep)
    begin
      next_ctrl = cev_ctrl_t'(CEV_CTRL_RST);
      next_route = CEV_ROUTE_RST;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl <= cev_ctrl_t'(CEV_CTRL_RST);
      route <= CEV_ROUTE_RST;
    end
    else
    begin
      ctrl <= next_ctrl;
      route <= next_route;
    end
  end

  always_comb
  begin
    case (axi_req.araddr)
      CEV_CTRL_OFF: rd_word = {24'h00_0000, ctrl};
      CEV_OPT_OFF: rd_word = {31'h0000_0000, route};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Outputs follow the next register value so pins match reads
  always_comb
  begin
    next_analog_enable = next_ctrl.en;
    next_noninv_sel_ref = next_ctrl.ref_sel;
    next_cmp_out_pin = next_ctrl.ope && next_ctrl.lvl;
    next_cmp_out_pin_oe_n = !next_ctrl.ope;
    next_timer_pin_disable = next_route;
    next_timer_capture_ch0_in = next_route ? next_ctrl.lvl : timer_pin_in;
    next_irq = next_ctrl.ie && next_ctrl.flag;
    next_wake_req = next_irq && (wait_mode || stop_light);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      analog_enable <= 1'b0;
      noninv_sel_ref <= 1'b0;
      cmp_out_pin <= 1'b0;
      cmp_out_pin_oe_n <= 1'b1;
      timer_capture_ch0_in <= 1'b0;
      timer_pin_disable <= 1'b0;
      irq <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      analog_enable <= next_analog_enable;
      noninv_sel_ref <= next_noninv_sel_ref;
      cmp_out_pin <= next_cmp_out_pin;
      cmp_out_pin_oe_n <= next_cmp_out_pin_oe_n;
      timer_capture_ch0_in <= next_timer_capture_ch0_in;
      timer_pin_disable <= next_timer_pin_disable;
      irq <= next_irq;
      wake_req <= next_wake_req;
    end
  end

  sequence s_rise_seen;
    ctrl.en && ctrl.mode == CEV_RISE && rise && !stop_deep;
  endsequence

  sequence s_flag_write(bit v);
    ctrl_wr && wr.data[CEV_FLAG_BIT] == v && !evt && !stop_deep;
  endsequence

  // Raw step is seen as an edge pulse two cycles later, after the synchroniser
  sequence s_raw_up;
    !cmp_raw ##1 cmp_raw;
  endsequence

  sequence s_raw_down;
    cmp_raw ##1 !cmp_raw;
  endsequence

  sequence s_rise_armed;
    ctrl.en && ctrl.mode == CEV_RISE && !stop_deep;
  endsequence

  a_flag_on_rise: assert property (@(posedge clk) disable iff (!nrst)
    s_rise_seen |=> ctrl.flag && irq == ctrl.ie)
    else $error("flag not set by rising edge");

  a_flag_w1c: assert property (@(posedge clk) disable iff (!nrst)
    s_flag_write(1'b1) |=> !ctrl.flag && !irq)
    else $error("flag not cleared by writing one");

  a_flag_w0_keep: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.flag ##0 s_flag_write(1'b0) |=> ctrl.flag)
    else $error("flag lost on writing zero");

  a_irq_follows: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.ie && ctrl.flag && !stop_deep && !ctrl_wr |=> irq)
    else $error("irq missing with flag and enable");

  a_irq_masked: assert property (@(posedge clk) disable iff (!nrst)
    !ctrl.ie |-> !irq)
    else $error("irq raised while masked");

  a_level_off: assert property (@(posedge clk) disable iff (!nrst)
    !ctrl.en |-> !ctrl.lvl && !cmp_out_pin)
    else $error("level visible while disabled");

  a_pin_drive: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.ope && ctrl.lvl |-> cmp_out_pin && !cmp_out_pin_oe_n)
    else $error("output pin not driven");

  a_fall_mode: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.en && ctrl.mode == CEV_FALL_B && rise && !fall && !ctrl.flag && !stop_deep
    |=> !ctrl.flag)
    else $error("rising edge flagged in falling mode");

  a_route_cap: assert property (@(posedge clk) disable iff (!nrst)
    route |-> timer_pin_disable && timer_capture_ch0_in == ctrl.lvl)
    else $error("capture channel not fed by comparator");

  a_enable_wr: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_wr && !stop_deep |=> analog_enable == $past(wr.data[CEV_EN_BIT]))
    else $error("enable write not applied");

  a_deep_reset: assert property (@(posedge clk) disable iff (!nrst)
    stop_deep |=> ctrl == cev_ctrl_t'(CEV_CTRL_RST) && !route && !irq)
    else $error("deep stop did not reset block");

  a_wake_wait: assert property (@(posedge clk) disable iff (!nrst)
    irq && wait_mode && !stop_deep && !ctrl_wr |=> wake_req)
    else $error("no wake request in wait");

  a_one_event: assert property (@(posedge clk) disable iff (!nrst)
    rise |=> !rise && !fall)
    else $error("transition gave two events");

  a_ref_select: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_wr && !stop_deep |=> noninv_sel_ref == $past(wr.data[CEV_REF_BIT]))
    else $error("reference select write not applied");

  a_fall_edge: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.en && ctrl.mode != CEV_RISE && fall && !stop_deep |=> ctrl.flag)
    else $error("falling edge not flagged");

  a_both_edges: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.en && ctrl.mode == CEV_BOTH && rise && !stop_deep |=> ctrl.flag)
    else $error("rising edge not flagged in toggle mode");

  a_disabled_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !ctrl.en && !ctrl.flag |=> !ctrl.flag)
    else $error("flag set while disabled");

  a_level_track: assert property (@(posedge clk) disable iff (!nrst)
    ctrl.en && !ctrl_wr && !stop_deep |=> ctrl.lvl == $past(sync_lvl))
    else $error("level bit does not follow comparator");

  a_timer_pass: assert property (@(posedge clk) disable iff (!nrst)
    !route && !opt_wr |=> !timer_pin_disable && timer_capture_ch0_in == $past(timer_pin_in))
    else $error("timer pin not passed through");

  a_opt_write: assert property (@(posedge clk) disable iff (!nrst)
    opt_wr && !stop_deep
    |=> route == $past(wr.data[CEV_ROUTE_BIT]) && timer_pin_disable == route)
    else $error("capture route write not applied");

  a_wake_light: assert property (@(posedge clk) disable iff (!nrst)
    irq && stop_light && !stop_deep && !ctrl_wr |=> wake_req)
    else $error("no wake request in light stop");

  a_no_wake_run: assert property (@(posedge clk) disable iff (!nrst)
    !wait_mode && !stop_light |=> !wake_req)
    else $error("wake request while running");

  a_raw_to_flag: assert property (@(posedge clk) disable iff (!nrst)
    s_raw_up ##2 s_rise_armed |=> ctrl.flag)
    else $error("raw rise did not set flag");

  a_raw_fall_flag: assert property (@(posedge clk) disable iff (!nrst)
    s_raw_down ##2 (ctrl.en && ctrl.mode != CEV_RISE && !stop_deep) |=> ctrl.flag)
    else $error("raw fall did not set flag");

  a_irq_chain: assert property (@(posedge clk) disable iff (!nrst)
    s_raw_up ##2 s_rise_armed ##0 (ctrl.ie && !ctrl_wr) |=> irq)
    else $error("raw rise did not raise irq");
endmodule

// *** cev_analog.sv ***
module cev_analog
(
  input wire logic sel_ref,
  input wire logic bg_buf_en,
  input wire logic signed [31:0] p_mv,
  input wire logic signed [31:0] r_mv,
  input wire logic signed [31:0] m_mv,
  output logic cmp_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [31:0] ref_mv;
  // Reference reaches the comparator only with its buffer powered
  assign ref_mv = bg_buf_en ? r_mv : 32'sh0000_0000;
  // Keeps comparing while disabled, so level gating is really tested
  assign cmp_raw = ((sel_ref ? ref_mv : p_mv) > m_mv);
endmodule

// *** comparator_event_control_tb.sv ***
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module comparator_event_control_tb
  import cev_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  cev_axi_req_t req = '0;
  cev_axi_resp_t resp;
  logic tpin = 1'b0;
  logic wm = 1'b0;
  logic sl = 1'b0;
  logic sd = 1'b0;
  logic bg_on = 1'b0;
  int p_mv = 300;
  int r_mv = 50;
  int m_mv = 200;
  int errors = 0;
  int n_tests = 0;
  logic cmp_raw, an_en, sel_ref, opin, oe_n, cap, tdis, irq, wake;
  logic [31:0] d;
  logic [1:0] r;

  cev_top dut (.clk(clk), .nrst(nrst), .axi_req(req), .axi_resp(resp), .cmp_raw(cmp_raw),
    .timer_pin_in(tpin), .wait_mode(wm), .stop_light(sl), .stop_deep(sd),
    .analog_enable(an_en), .noninv_sel_ref(sel_ref), .cmp_out_pin(opin),
    .cmp_out_pin_oe_n(oe_n), .timer_capture_ch0_in(cap), .timer_pin_disable(tdis),
    .irq(irq), .wake_req(wake));
  cev_analog ana (.sel_ref(sel_ref), .bg_buf_en(bg_on), .p_mv(p_mv), .r_mv(r_mv), .m_mv(m_mv),
    .cmp_raw(cmp_raw));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic st(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic setp(input int v);
    @(posedge clk);
    p_mv <= v;
    st(6);
  endtask

  // Each valid drops at its own handshake; only the watchdog ends a wait
  task automatic wr(input logic [31:0] a, input logic [7:0] v);
    logic done;
    done = 1'b0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= 32'(v);
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (req.awvalid && resp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && resp.wready)
        req.wvalid <= 1'b0;
      if (resp.bvalid)
      begin
        r = resp.bresp;
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [31:0] a);
    logic done;
    done = 1'b0;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (req.arvalid && resp.arready)
        req.arvalid <= 1'b0;
      if (resp.rvalid)
      begin
        d = resp.rdata;
        r = resp.rresp;
        req.rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic t_reset;
    `CHK("oe_n", 1'b1, oe_n)
    `CHK("irq", 1'b0, irq)
    rd(CEV_CTRL_OFF);
    `CHK("ctrl", 32'h0000_0000, d)
    rd(CEV_OPT_OFF);
    `CHK("opt", 32'h0000_0000, d)
    rd(32'h0000_0008);
    `CHK("bad rresp", CEV_RESP_SLVERR, r)
    wr(32'h0000_0010, 8'hff);
    `CHK("bad bresp", CEV_RESP_SLVERR, r)
  endtask

  task automatic t_enable;
    wr(CEV_CTRL_OFF, 8'h80);
    st(6);
    `CHK("en", 1'b1, an_en)
    rd(CEV_CTRL_OFF);
    `CHK("lvl on", 32'h0000_0088, d)
    @(posedge clk);
    bg_on <= 1'b1;
    wr(CEV_CTRL_OFF, 8'hc0);
    st(6);
    `CHK("sel", 1'b1, sel_ref)
    rd(CEV_CTRL_OFF);
    `CHK("ref fall", 32'h0000_00e0, d)
    wr(CEV_CTRL_OFF, 8'h20);
    st(6);
    `CHK("en off", 1'b0, an_en)
    rd(CEV_CTRL_OFF);
    `CHK("lvl off", 32'h0000_0000, d)
  endtask

  task automatic t_edges;
    for (int m = 0; m < 4; m++)
    begin
      setp(100);
      wr(CEV_CTRL_OFF, 8'ha0 | 8'(m));
      setp(300);
      rd(CEV_CTRL_OFF);
      `CHK("rise", logic'(m == 1 || m == 3), d[CEV_FLAG_BIT])
      wr(CEV_CTRL_OFF, 8'ha0 | 8'(m));
      setp(100);
      rd(CEV_CTRL_OFF);
      `CHK("fall", logic'(m != 1), d[CEV_FLAG_BIT])
      wr(CEV_CTRL_OFF, 8'h80 | 8'(m));
      rd(CEV_CTRL_OFF);
      `CHK("w0 keep", logic'(m != 1), d[CEV_FLAG_BIT])
    end
  endtask

  task automatic t_irq;
    wr(CEV_CTRL_OFF, 8'hb1);
    @(posedge clk);
    wm <= 1'b1;
    setp(300);
    `CHK("irq", 1'b1, irq)
    `CHK("wake wait", 1'b1, wake)
    wr(CEV_CTRL_OFF, 8'hb1);
    st(2);
    `CHK("irq clr", 1'b0, irq)
    @(posedge clk);
    wm <= 1'b0;
    sl <= 1'b1;
    wr(CEV_CTRL_OFF, 8'h85);
    setp(100);
    setp(300);
    `CHK("irq off", 1'b0, irq)
    `CHK("pin", 1'b1, opin)
    `CHK("pin oe", 1'b0, oe_n)
    wr(CEV_CTRL_OFF, 8'h95);
    st(2);
    `CHK("wake stop", 1'b1, wake)
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    sl <= 1'b0;
    st(2);
    `CHK("rst oe", 1'b1, oe_n)
    rd(CEV_CTRL_OFF);
    `CHK("rst ctrl", 32'h0000_0000, d)
  endtask

  task automatic t_route;
    wr(CEV_CTRL_OFF, 8'h80);
    wr(CEV_OPT_OFF, 8'h01);
    @(posedge clk);
    tpin <= 1'b1;
    setp(100);
    `CHK("cap lo", 1'b0, cap)
    `CHK("tdis", 1'b1, tdis)
    @(posedge clk);
    tpin <= 1'b0;
    setp(300);
    `CHK("cap hi", 1'b1, cap)
    wr(CEV_OPT_OFF, 8'h00);
    st(2);
    `CHK("cap pin", 1'b0, cap)
    `CHK("tdis off", 1'b0, tdis)
    wr(CEV_CTRL_OFF, 8'h00);
    @(posedge clk);
    wm <= 1'b1;
    st(2);
    `CHK("wait off", 1'b0, an_en)
    `CHK("wait no wake", 1'b0, wake)
    @(posedge clk);
    wm <= 1'b0;
  endtask

  task automatic t_deep;
    wr(CEV_CTRL_OFF, 8'h94);
    wr(CEV_OPT_OFF, 8'h01);
    @(posedge clk);
    sd <= 1'b1;
    st(3);
    @(posedge clk);
    sd <= 1'b0;
    st(2);
    `CHK("deep oe", 1'b1, oe_n)
    rd(CEV_CTRL_OFF);
    `CHK("deep ctrl", 32'h0000_0000, d)
    rd(CEV_OPT_OFF);
    `CHK("deep opt", 32'h0000_0000, d)
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    st(1);
    t_reset();
    t_enable();
    t_edges();
    t_irq();
    t_route();
    t_deep();
    print_verdict();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule
